// File: rtl/ulm_top.sv
// Purpose: one uart channel: framing, line status, modem control/status
// Assumes: axi4-lite slave, single clock, synchronous active-high reset
// Notes:   pins pass two flops, irq_req_i only one; outputs are all registered
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module ulm_top
	import ulm_pkg::*;
#(
	parameter int DEPTH    = 64, // fifo depth, both directions
	parameter int RTS_HALT = 60  // auto rts halt fill level
) (
	// clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              reset_i,
	// axi4-lite write
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	// serial and modem pins
	input  wire logic              rx_i,
	output logic                   tx_o,
	input  wire logic              cts_n_i,
	input  wire logic              dsr_n_i,
	input  wire logic              ri_n_i,
	input  wire logic              cd_n_i,
	output logic                   dtr_n_o,
	output logic                   rts_n_o,
	input  wire logic              clock_prescale_select_pin_i,
	// interrupt pin from outside interrupt logic
	input  wire logic              irq_req_i,
	output logic                   irq_o,
	output logic                   irq_oe_o
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
	localparam logic [PW:0] HALT = (PW+1)'(RTS_HALT);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [5:0] sync1_ff; // first stage, read by second only
	logic [5:0] sync2_ff; // {clock_prescale_select_pin, cd, ri, dsr, cts, rx}
	// two flops per pin, free running
	always_ff @(posedge sys_clk_i) begin
		sync1_ff <= {clock_prescale_select_pin_i, cd_n_i, ri_n_i, dsr_n_i, cts_n_i, rx_i};
		sync2_ff <= sync1_ff;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0]  lfc_ff;   // line_format_control
	logic [7:0]  moc_ff;   // modem_output_control
	logic [1:0]  aux_ff;   // enhanced and auto rts enables
	logic [15:0] div_ff;   // baud divisor latches
	logic        rst_d_ff; // reset seen last cycle
	logic        lb;       // loopback active
	logic        dlab;     // divisor access
	logic [1:0]  wl;       // word length code
	assign lb   = moc_ff[MC_LOOP];
	assign dlab = lfc_ff[LF_DLAB];
	assign wl   = lfc_ff[1:0];

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	logic              aw_got_ff, w_got_ff;
	logic [ADDR_W-1:0] aw_ff;     // held write address
	logic [31:0]       wd_ff;     // held write data
	logic [3:0]        ws_ff;     // held strobes
	logic              awr_ff, wr_ff, bv_ff, arr_ff, rv_ff;
	logic [1:0]        bresp_ff, rresp_ff;
	logic [31:0]       rd_ff;
	logic              do_wr, ar_hs;
	logic              nxt_aw_got, nxt_w_got, nxt_bv, nxt_rv;
	always_comb begin
		do_wr      = aw_got_ff & w_got_ff;
		ar_hs      = s_axi_arvalid_i & arr_ff;
		nxt_aw_got = ~do_wr & (aw_got_ff | (s_axi_awvalid_i & awr_ff));
		nxt_w_got  = ~do_wr & (w_got_ff | (s_axi_wvalid_i & wr_ff));
		nxt_bv     = do_wr | (bv_ff & ~s_axi_bready_i);
		nxt_rv     = ar_hs | (rv_ff & ~s_axi_rready_i);
	end
	// handshake state; one write and one read at a time
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			aw_got_ff <= 1'b0;
			w_got_ff  <= 1'b0;
			awr_ff    <= 1'b0;
			wr_ff     <= 1'b0;
			bv_ff     <= 1'b0;
			arr_ff    <= 1'b0;
			rv_ff     <= 1'b0;
		end else begin
			aw_got_ff <= nxt_aw_got;
			w_got_ff  <= nxt_w_got;
			awr_ff    <= ~nxt_aw_got & ~nxt_bv;
			wr_ff     <= ~nxt_w_got & ~nxt_bv;
			bv_ff     <= nxt_bv;
			arr_ff    <= ~nxt_rv;
			rv_ff     <= nxt_rv;
		end
	end
	// payload capture
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			aw_ff <= '0;
			wd_ff <= '0;
			ws_ff <= '0;
		end else begin
			if (s_axi_awvalid_i & awr_ff) begin
				aw_ff <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i & wr_ff) begin
				wd_ff <= s_axi_wdata_i;
				ws_ff <= s_axi_wstrb_i;
			end
		end
	end

	// address decode, word granularity
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] o);
		hit = (a[ADDR_W-1:2] == o[ADDR_W-1:2]);
	endfunction
	logic wen;   // lane 0 carries every register
	logic w_dat, w_dhi, w_aux, w_lfc, w_moc, w_ok;
	always_comb begin
		wen   = do_wr & ws_ff[0];
		w_dat = wen & hit(aw_ff, ADR_DATA);
		w_dhi = wen & hit(aw_ff, ADR_DIVHI) & dlab;
		w_aux = wen & hit(aw_ff, ADR_AUX);
		w_lfc = wen & hit(aw_ff, ADR_LFC);
		w_moc = wen & hit(aw_ff, ADR_MOC);
		w_ok  = hit(aw_ff, ADR_DATA) | (hit(aw_ff, ADR_DIVHI) & dlab) | hit(aw_ff, ADR_AUX)
		      | hit(aw_ff, ADR_LFC) | hit(aw_ff, ADR_MOC) | hit(aw_ff, ADR_LCF)
		      | hit(aw_ff, ADR_MIF) | hit(aw_ff, ADR_FRDY);
	end
	// write response code
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			bresp_ff <= RESP_OKAY;
		end else if (do_wr) begin
			bresp_ff <= w_ok ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// ----------------------------------------
	// control register writes
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			lfc_ff   <= LFC_RST;
			aux_ff   <= '0;
			div_ff   <= DIV_RST;
			rst_d_ff <= 1'b1;
			moc_ff   <= MOC_RST;
		end else begin
			rst_d_ff <= 1'b0;
			if (w_lfc) begin
				lfc_ff <= wd_ff[7:0];
			end
			if (w_aux) begin
				aux_ff <= wd_ff[1:0];
			end
			if (w_dat & dlab) begin
				div_ff[7:0] <= wd_ff[7:0];
			end
			if (w_dhi) begin
				div_ff[15:8] <= wd_ff[7:0];
			end
			if (rst_d_ff) begin
				moc_ff[MC_PRE] <= ~sync2_ff[5];
			end else if (w_moc) begin
				moc_ff[4:0] <= wd_ff[4:0];
				if (aux_ff[AX_ENH]) begin
					moc_ff[7:5] <= wd_ff[7:5];
				end
			end
		end
	end

	// ----------------------------------------
	// baud tick: prescale then divisor, 16x
	// ----------------------------------------
	logic [1:0]  pre_ff;
	logic [15:0] bcnt_ff;
	logic        tick_ff;
	logic        pre_en;
	assign pre_en = ~moc_ff[MC_PRE] | (pre_ff == PRE_LAST);
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			pre_ff  <= '0;
			bcnt_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			pre_ff  <= pre_ff + 2'h1;
			tick_ff <= 1'b0;
			if (pre_en) begin
				if ((bcnt_ff + 16'h0001) >= div_ff) begin
					bcnt_ff <= '0;
					tick_ff <= 1'b1;
				end else begin
					bcnt_ff <= bcnt_ff + 16'h0001;
				end
			end
		end
	end

	// parity of a character under current format
	function automatic logic par_of(input logic [7:0] d, input logic [7:0] f);
		logic [7:0] m;
		m = 8'hFF >> (2'h3 - f[1:0]);
		if (f[LF_FRC]) begin
			par_of = ~f[LF_EVN];
		end else begin
			par_of = f[LF_EVN] ? ^(d & m) : ~^(d & m);
		end
	endfunction

	// ----------------------------------------
	// transmit fifo and shifter
	// ----------------------------------------
	logic [7:0]  tmem [DEPTH];
	logic [PW-1:0] twp_ff, trp_ff;
	logic [PW:0]   tcnt_ff;
	ulm_ser_e    ts_ff;
	logic [4:0]  tt_ff;     // ticks within bit
	logic [2:0]  tb_ff;     // bit index
	logic [7:0]  tsh_ff;    // shift data
	logic        tline_ff;  // internal serial line
	logic        t_push, t_pop;
	logic [4:0]  stop_end;
	assign t_push = w_dat & ~dlab & (tcnt_ff != FULL); // full: character lost
	assign t_pop  = (ts_ff == S_IDLE) & (tcnt_ff != '0);
	always_comb begin
		if (~lfc_ff[LF_STP]) begin
			stop_end = T_STOP1;
		end else if (wl == 2'h0) begin
			stop_end = T_STOP15;
		end else begin
			stop_end = T_STOP2;
		end
	end
	// fifo pointers
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			twp_ff  <= '0;
			trp_ff  <= '0;
			tcnt_ff <= '0;
		end else begin
			if (t_push) begin
				tmem[twp_ff] <= wd_ff[7:0];
				twp_ff       <= twp_ff + 1'b1;
			end
			if (t_pop) begin
				trp_ff <= trp_ff + 1'b1;
			end
			tcnt_ff <= tcnt_ff + (PW+1)'(t_push) - (PW+1)'(t_pop);
		end
	end
	// frame sender
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			ts_ff    <= S_IDLE;
			tt_ff    <= '0;
			tb_ff    <= '0;
			tsh_ff   <= '0;
			tline_ff <= 1'b1;
		end else begin
			case (ts_ff)
				S_IDLE: begin
					tline_ff <= 1'b1;
					if (t_pop) begin
						tsh_ff   <= tmem[trp_ff];
						tt_ff    <= '0;
						tline_ff <= 1'b0;
						ts_ff    <= S_STRT;
					end
				end
				S_STRT, S_DATA, S_PAR, S_STOP: begin
					if (tick_ff) begin
						tt_ff <= tt_ff + 5'h01;
						if (ts_ff != S_STOP && tt_ff == T_BIT) begin
							tt_ff <= '0;
							if (ts_ff == S_STRT) begin
								tb_ff    <= '0;
								tline_ff <= tsh_ff[0];
								ts_ff    <= S_DATA;
							end else if (ts_ff == S_DATA && tb_ff != {1'b1, wl}) begin
								tb_ff    <= tb_ff + 3'h1;
								tline_ff <= tsh_ff[tb_ff + 3'h1];
							end else if (ts_ff == S_DATA && lfc_ff[LF_PEN]) begin
								tline_ff <= par_of(tsh_ff, lfc_ff);
								ts_ff    <= S_PAR;
							end else begin
								tline_ff <= 1'b1;
								ts_ff    <= S_STOP;
							end
						end else if (ts_ff == S_STOP && tt_ff == stop_end) begin
							ts_ff <= S_IDLE;
						end
					end
				end
				default: ts_ff <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	logic [E_W-1:0] rmem [DEPTH];
	logic [PW-1:0]  rwp_ff, rrp_ff;
	logic [PW:0]    rcnt_ff, ecnt_ff;
	ulm_ser_e       rs_ff;
	logic [4:0]     rt_ff;
	logic [2:0]     rb_ff;
	logic [7:0]     rsh_ff;
	logic           rpe_ff, rpb_ff, rprev_ff, ovr_ff;
	logic           rsrc, r_push, r_pop, r_stop;
	logic [7:0]     rdat;
	logic [E_W-1:0] rent, rhead;
	logic           rd_lcf, rd_mif;
	assign rsrc  = lb ? tline_ff : sync2_ff[0];
	assign rdat  = rsh_ff >> (2'h3 - wl);
	assign r_stop = (rs_ff == S_STOP) & tick_ff & (rt_ff == T_BIT);
	always_comb begin
		rent         = {3'h0, rdat};
		rent[E_PE]   = rpe_ff;
		rent[E_FE]   = ~rsrc;
		rent[E_BI]   = ~rsrc & (rdat == 8'h00) & ~rpb_ff;
		if (rent[E_BI]) begin
			rent[E_PE] = 1'b0;
		end
	end
	assign r_push = r_stop & (rcnt_ff != FULL);
	assign r_pop  = ar_hs & hit(s_axi_araddr_i, ADR_DATA) & ~dlab & (rcnt_ff != '0);
	assign rhead  = rmem[rrp_ff];
	assign rd_lcf = ar_hs & hit(s_axi_araddr_i, ADR_LCF);
	assign rd_mif = ar_hs & hit(s_axi_araddr_i, ADR_MIF);
	// frame receiver, samples mid-bit
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			rs_ff    <= S_IDLE;
			rt_ff    <= '0;
			rb_ff    <= '0;
			rsh_ff   <= '0;
			rpe_ff   <= 1'b0;
			rpb_ff   <= 1'b0;
			rprev_ff <= 1'b1;
		end else begin
			rprev_ff <= rsrc;
			case (rs_ff)
				S_IDLE: begin
					rt_ff  <= '0;
					rpe_ff <= 1'b0;
					rpb_ff <= 1'b0;
					if (rprev_ff & ~rsrc) begin
						rs_ff <= S_STRT;
					end
				end
				S_STRT: begin
					if (tick_ff) begin
						rt_ff <= rt_ff + 5'h01;
						if (rt_ff == T_MID) begin
							rt_ff <= '0;
							rb_ff <= '0;
							rs_ff <= rsrc ? S_IDLE : S_DATA;
						end
					end
				end
				S_DATA, S_PAR, S_STOP: begin
					if (tick_ff) begin
						rt_ff <= rt_ff + 5'h01;
						if (rt_ff == T_BIT) begin
							rt_ff <= '0;
							if (rs_ff == S_DATA) begin
								rsh_ff <= {rsrc, rsh_ff[7:1]};
								rb_ff  <= rb_ff + 3'h1;
								if (rb_ff == {1'b1, wl}) begin
									rs_ff <= lfc_ff[LF_PEN] ? S_PAR : S_STOP;
								end
							end else if (rs_ff == S_PAR) begin
								rpb_ff <= rsrc;
								rpe_ff <= rsrc ^ par_of(rdat, lfc_ff);
								rs_ff  <= S_STOP;
							end else begin
								rs_ff <= S_IDLE;
							end
						end
					end
				end
				default: rs_ff <= S_IDLE;
			endcase
		end
	end
	// receive fifo with flagged-entry count
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			rwp_ff  <= '0;
			rrp_ff  <= '0;
			rcnt_ff <= '0;
			ecnt_ff <= '0;
			ovr_ff  <= 1'b0;
		end else begin
			if (r_push) begin
				rmem[rwp_ff] <= rent;
				rwp_ff       <= rwp_ff + 1'b1;
			end
			if (r_pop) begin
				rrp_ff <= rrp_ff + 1'b1;
			end
			rcnt_ff <= rcnt_ff + (PW+1)'(r_push) - (PW+1)'(r_pop);
			ecnt_ff <= ecnt_ff + (PW+1)'(r_push & |rent[E_BI:E_PE])
			         - (PW+1)'(r_pop & |rhead[E_BI:E_PE]);
			// set wins over the read clear
			ovr_ff <= (r_stop & (rcnt_ff == FULL)) | (ovr_ff & ~rd_lcf);
		end
	end

	// ----------------------------------------
	// modem status
	// ----------------------------------------
	logic [3:0] mst;     // {cd, ri, dsr, cts}, active high
	logic [3:0] mprv_ff;
	logic [3:0] dlt_ff;
	logic [3:0] chg;
	always_comb begin
		if (lb) begin
			mst = {moc_ff[MC_IRQ], moc_ff[MC_RDY], moc_ff[MC_DTR], moc_ff[MC_RTS]};
		end else begin
			mst = ~sync2_ff[4:1];
		end
		chg    = mst ^ mprv_ff;
		chg[2] = mst[2] & ~mprv_ff[2];
	end
	// deltas: a change in the read cycle is kept
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			mprv_ff <= '0;
			dlt_ff  <= '0;
		end else begin
			mprv_ff <= mst;
			dlt_ff  <= chg | (dlt_ff & {4{~rd_mif}});
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	logic [7:0] lcf;
	logic [7:0] rmux;
	logic       r_ok;
	logic       t_empty;
	assign t_empty = (tcnt_ff == '0);
	always_comb begin
		lcf      = '0;
		lcf[0]   = (rcnt_ff != '0);
		lcf[1]   = ovr_ff;
		lcf[4:2] = (rcnt_ff != '0) ? {rhead[E_BI], rhead[E_FE], rhead[E_PE]} : 3'h0;
		lcf[5]   = t_empty;
		lcf[6]   = t_empty & (ts_ff == S_IDLE);
		lcf[7]   = (ecnt_ff != '0);
		rmux     = '0;
		r_ok     = 1'b1;
		if (hit(s_axi_araddr_i, ADR_DATA)) begin
			rmux = dlab ? div_ff[7:0] : ((rcnt_ff != '0) ? rhead[7:0] : 8'h00);
		end else if (hit(s_axi_araddr_i, ADR_DIVHI) & dlab) begin
			rmux = div_ff[15:8];
		end else if (hit(s_axi_araddr_i, ADR_AUX)) begin
			rmux = {6'h00, aux_ff};
		end else if (hit(s_axi_araddr_i, ADR_LFC)) begin
			rmux = lfc_ff;
		end else if (hit(s_axi_araddr_i, ADR_MOC)) begin
			rmux = moc_ff;
		end else if (hit(s_axi_araddr_i, ADR_LCF)) begin
			rmux = lcf;
		end else if (hit(s_axi_araddr_i, ADR_MIF)) begin
			rmux = {mst, dlt_ff};
		end else if (hit(s_axi_araddr_i, ADR_FRDY)) begin
			if (moc_ff[MC_RDY] & ~lb) begin
				rmux = {3'h0, (rcnt_ff != '0), 3'h0, (tcnt_ff != FULL)};
			end
		end else begin
			r_ok = 1'b0;
		end
	end
	// read answer registers
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			rd_ff    <= '0;
			rresp_ff <= RESP_OKAY;
		end else if (ar_hs) begin
			rd_ff    <= {24'h000000, rmux};
			rresp_ff <= r_ok ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	logic tx_ff, dtr_ff, rts_ff, irq_ff, irqoe_ff;
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			tx_ff    <= 1'b1;
			dtr_ff   <= 1'b1;
			rts_ff   <= 1'b1;
			irq_ff   <= 1'b0;
			irqoe_ff <= 1'b0;
		end else begin
			tx_ff  <= lb | (tline_ff & ~lfc_ff[LF_BRK]);
			dtr_ff <= lb | ~moc_ff[MC_DTR];
			if (lb) begin
				rts_ff <= 1'b1;
			end else if (aux_ff[AX_ARTS]) begin
				rts_ff <= (rcnt_ff >= HALT);
			end else begin
				rts_ff <= ~moc_ff[MC_RTS];
			end
			irq_ff   <= irq_req_i;
			irqoe_ff <= moc_ff[MC_IRQ];
		end
	end

	assign s_axi_awready_o = awr_ff;
	assign s_axi_wready_o  = wr_ff;
	assign s_axi_bvalid_o  = bv_ff;
	assign s_axi_bresp_o   = bresp_ff;
	assign s_axi_arready_o = arr_ff;
	assign s_axi_rvalid_o  = rv_ff;
	assign s_axi_rdata_o   = rd_ff;
	assign s_axi_rresp_o   = rresp_ff;
	assign tx_o            = tx_ff;
	assign dtr_n_o         = dtr_ff;
	assign rts_n_o         = rts_ff;
	assign irq_o           = irq_ff;
	assign irq_oe_o        = irqoe_ff;
endmodule
`default_nettype wire

// File: rtl/ulm_pkg.sv
// Purpose: shared constants for the uart line and modem control block
// Assumes: axi4-lite register access, 32-bit data, one word per register
// Notes:   offsets are byte addresses
package ulm_pkg;
	// ----------------------------------------
	// bus geometry and answers
	// ----------------------------------------
	localparam int         ADDR_W      = 6;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [5:0] ADR_DATA   = 6'h00; // holding fifos or divisor low
	localparam logic [5:0] ADR_DIVHI  = 6'h04; // divisor high (latch access)
	localparam logic [5:0] ADR_AUX    = 6'h08; // enhanced / auto-rts control
	localparam logic [5:0] ADR_LFC    = 6'h0C; // line_format_control
	localparam logic [5:0] ADR_MOC    = 6'h10; // modem_output_control
	localparam logic [5:0] ADR_LCF    = 6'h14; // line_condition_flags
	localparam logic [5:0] ADR_MIF    = 6'h18; // modem_input_flags
	localparam logic [5:0] ADR_FRDY   = 6'h1C; // fifo_ready_summary
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int LF_DLAB = 7; // divisor latch access
	localparam int LF_BRK  = 6; // break control
	localparam int LF_FRC  = 5; // forced parity
	localparam int LF_EVN  = 4; // even select
	localparam int LF_PEN  = 3; // parity enable
	localparam int LF_STP  = 2; // stop select
	localparam int MC_PRE  = 7; // divide-by-four prescale
	localparam int MC_LOOP = 4; // local loopback
	localparam int MC_IRQ  = 3; // irq drive enable
	localparam int MC_RDY  = 2; // fifo ready summary enable
	localparam int MC_RTS  = 1;
	localparam int MC_DTR  = 0;
	localparam int AX_ENH  = 0; // enhanced_feature_enable
	localparam int AX_ARTS = 1; // auto rts enable
	localparam int E_PE    = 8; // rx entry parity flag
	localparam int E_FE    = 9; // rx entry framing flag
	localparam int E_BI    = 10; // rx entry break flag
	localparam int E_W     = 11;
	// ----------------------------------------
	// reset values and timing
	// ----------------------------------------
	localparam logic [7:0]  LFC_RST    = 8'h00;
	localparam logic [7:0]  MOC_RST    = 8'h00;
	localparam logic [15:0] DIV_RST    = 16'h0001;
	localparam logic [4:0]  T_BIT      = 5'h0F; // last tick of a bit
	localparam logic [4:0]  T_MID      = 5'h07; // mid start bit
	localparam logic [4:0]  T_STOP1    = 5'h0F; // one stop bit
	localparam logic [4:0]  T_STOP15   = 5'h17; // one and a half
	localparam logic [4:0]  T_STOP2    = 5'h1F; // two stop bits
	localparam logic [1:0]  PRE_LAST   = 2'h3; // divide by four
	// ----------------------------------------
	// serial state machines
	// ----------------------------------------
	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_STRT = 5'h02,
		S_DATA = 5'h04,
		S_PAR  = 5'h08,
		S_STOP = 5'h10
	} ulm_ser_e;
endpackage

// File: tb/ulm_top_asserts.sv
// Purpose: port checks for ulm_top
// Assumes: one clock, sync reset
// Notes:   bound from the bench top
`timescale 1ns/10ps
`default_nettype none
module ulm_top_asserts (
	// clock, reset and bus
	input wire logic        sys_clk_i, reset_i,
	input wire logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i,
	input wire logic        s_axi_wready_o, s_axi_bvalid_o, s_axi_arvalid_i,
	input wire logic        s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i,
	input wire logic [31:0] s_axi_rdata_o,
	// pins
	input wire logic        tx_o, dtr_n_o, rts_n_o, irq_req_i, irq_o, irq_oe_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	// both halves of a write taken together
	sequence wr_taken;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	// one held cycle, then the answer
	sequence wr_answer;
		!s_axi_bvalid_o ##1 s_axi_bvalid_o;
	endsequence
	wr_resp_a: assert property (wr_taken |=> wr_answer)
		else $error("write answer late");
	rd_resp_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
	rd_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
	rd_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read taken while busy");
	wr_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken while busy");
	rd_pad_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	irq_follow_a: assert property (!$past(reset_i) |-> irq_o == $past(irq_req_i))
		else $error("irq pin not following request");
	rst_idle_a: assert property ($past(reset_i) |-> tx_o && dtr_n_o && rts_n_o && !irq_oe_o)
		else $error("pins not idle after reset");
endmodule
`default_nettype wire

// File: tb/ulm_peer.sv
// Purpose: serial peer and modem lines
// Assumes: 16 clocks a bit
// Notes:   line idles high
`timescale 1ns/10ps
`default_nettype none
module ulm_peer (
	// clock
	input wire logic clk_i,
	// lines to the uart
	output var logic rx_o,
	output var logic cts_n_o
);
	// idle line, clear-to-send inactive
	initial begin
		rx_o = 1'h1;
		cts_n_o = 1'h1;
	end
	// send frame bits lsb first, then idle
	task automatic send(input logic [11:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			rx_o <= f[i];
			repeat (16) @(posedge clk_i);
		end
		rx_o <= 1'h1;
	endtask
endmodule
`default_nettype wire

// File: tb/tb_ulm_top.sv
// Purpose: self-checking bench for ulm_top
// Assumes: divisor 1, prescale 1
// Notes:   peer drives rx and cts
`timescale 1ns/10ps
`default_nettype none
module tb_ulm_top
	import ulm_pkg::*;
;
	// bench state
	integer            seed = 32'h1277A785;
	int                num_errors = 0;
	int                n_compared = 0;
	logic [7:0]        lf, d;
	logic [11:0]       f;
	int                n;
	// design pins, named as the ports
	logic              sys_clk_i = 1'h0;
	logic              reset_i = 1'h1;
	logic [ADDR_W-1:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
	logic [31:0]       s_axi_wdata_i = '0, s_axi_rdata_o;
	logic [1:0]        s_axi_bresp_o, s_axi_rresp_o;
	logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
	logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0, irq_req_i = 1'h0;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
	logic s_axi_rvalid_o, rx_i, tx_o, cts_n_i, dtr_n_o, rts_n_o, irq_o, irq_oe_o;
	// strap and idle modem inputs
	wire logic [3:0] s_axi_wstrb_i = 4'hF;
	wire logic dsr_n_i = 1'h1, ri_n_i = 1'h1, cd_n_i = 1'h1;
	wire logic clock_prescale_select_pin_i = 1'h1;
	always #5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) irq_req_i <= 1'($random(seed));
	ulm_top dut (.*);
	ulm_peer peer (.clk_i(sys_clk_i), .rx_o(rx_i), .cts_n_o(cts_n_i));
	// compare and count
	task automatic chk(input logic [7:0] g, e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("Error at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	// register write, address and data offered together
	task automatic wr(input logic [5:0] a, input logic [7:0] v, input logic [1:0] r = RESP_OKAY);
		logic ta, tw;
		ta = 1'h0;
		tw = 1'h0;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= {24'h0, v};
		s_axi_awvalid_i <= 1'h1;
		s_axi_wvalid_i <= 1'h1;
		do begin
			@(posedge sys_clk_i);
			ta = ta | s_axi_awready_o;
			tw = tw | s_axi_wready_o;
			if (ta) s_axi_awvalid_i <= 1'h0;
			if (tw) s_axi_wvalid_i <= 1'h0;
		end while (!(ta && tw));
		// raised after the offer: back-to-back calls never drive it twice at one edge
		s_axi_bready_i <= 1'h1;
		do @(posedge sys_clk_i); while (!s_axi_bvalid_o);
		s_axi_bready_i <= 1'h0;
		chk({6'h0, s_axi_bresp_o}, {6'h0, r});
	endtask
	// register read, data masked, rready one cycle late
	task automatic rd(input logic [5:0] a, input logic [7:0] m, e, input logic [1:0] r = RESP_OKAY);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'h1;
		do @(posedge sys_clk_i); while (!s_axi_arready_o);
		s_axi_arvalid_i <= 1'h0;
		@(posedge sys_clk_i);
		s_axi_rready_i <= 1'h1;
		do @(posedge sys_clk_i); while (!s_axi_rvalid_o);
		s_axi_rready_i <= 1'h0;
		chk({6'h0, s_axi_rresp_o}, {6'h0, r});
		if (r == RESP_OKAY) chk(s_axi_rdata_o[7:0] & m, e);
	endtask
	// parity bit for data v under format c
	function automatic logic par(input logic [7:0] v, c);
		if (c[LF_FRC]) return !c[LF_EVN];
		return c[LF_EVN] ? ^v : ~^v;
	endfunction
	task automatic report_and_stop();
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (30000) @(posedge sys_clk_i);
		num_errors++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(posedge sys_clk_i);
		reset_i <= 1'h0;
		@(posedge sys_clk_i);
		rd(ADR_LFC, 8'hFF, LFC_RST);
		rd(ADR_MOC, 8'hFF, 8'h00);
		rd(ADR_LCF, 8'hFF, 8'h60);
		wr(ADR_MOC, 8'hE0);
		rd(ADR_MOC, 8'hFF, 8'h00);
		wr(ADR_LFC, 8'h83);
		rd(ADR_DATA, 8'hFF, 8'h01);
		wr(ADR_DIVHI, 8'h00);
		wr(ADR_LFC, 8'h03);
		rd(ADR_DIVHI, 8'h00, 8'h00, RESP_SLVERR);
		rd(6'h20, 8'h00, 8'h00, RESP_SLVERR);
		wr(ADR_AUX, 8'h03);
		wr(ADR_MOC, 8'h64);
		rd(ADR_MOC, 8'hFF, 8'h64);
		rd(ADR_FRDY, 8'hFF, 8'h01);
		chk({7'h0, rts_n_o}, 8'h00);
		wr(ADR_MOC, 8'h00);
		wr(ADR_AUX, 8'h00);
		$display("register test done");
		rd(ADR_MIF, 8'hFF, 8'h00);
		peer.cts_n_o <= 1'h0;
		repeat (4) @(posedge sys_clk_i);
		rd(ADR_MIF, 8'hFF, 8'h11);
		rd(ADR_MIF, 8'hFF, 8'h10);
		wr(ADR_MOC, 8'h13);
		repeat (4) @(posedge sys_clk_i);
		rd(ADR_MIF, 8'hFF, 8'h32);
		chk({6'h0, dtr_n_o, rts_n_o}, 8'h03);
		wr(ADR_DATA, 8'h5A);
		repeat (250) @(posedge sys_clk_i);
		rd(ADR_LCF, 8'h01, 8'h01);
		rd(ADR_DATA, 8'hFF, 8'h5A);
		wr(ADR_MOC, 8'h0B);
		repeat (2) @(posedge sys_clk_i);
		chk({5'h0, irq_oe_o, dtr_n_o, rts_n_o}, 8'h04);
		$display("modem test done");
		// every length, both parities, random forcing; one bad parity
		for (int i = 0; i < 8; i++) begin
			lf = {2'h0, 1'($random(seed)), i[2], 1'h1, 1'($random(seed)), i[1:0]};
			n = 5 + i[1:0];
			d = 8'($random(seed)) & (8'hFF >> (8 - n));
			f = 12'hFFF;
			f[0] = 1'h0;
			for (int j = 0; j < n; j++) f[j+1] = d[j];
			f[n+1] = par(d, lf) ^ (i == 6);
			wr(ADR_LFC, lf);
			peer.send(f, n + 3);
			repeat (8) @(posedge sys_clk_i);
			rd(ADR_LCF, 8'hFF, (i == 6) ? 8'hE5 : 8'h61);
			rd(ADR_LCF, 8'hFF, (i == 6) ? 8'hE5 : 8'h61);
			rd(ADR_DATA, 8'hFF, d);
			rd(ADR_LCF, 8'hFF, 8'h60);
		end
		wr(ADR_LFC, 8'h03);
		peer.send(12'hC00, 12);
		repeat (8) @(posedge sys_clk_i);
		rd(ADR_LCF, 8'hFF, 8'hF9);
		rd(ADR_DATA, 8'hFF, 8'h00);
		$display("receive test done");
		wr(ADR_LFC, 8'h07);
		wr(ADR_DATA, 8'hA5);
		rd(ADR_LCF, 8'h40, 8'h00);
		repeat (165) @(posedge sys_clk_i);
		rd(ADR_LCF, 8'h40, 8'h00);
		repeat (30) @(posedge sys_clk_i);
		rd(ADR_LCF, 8'h60, 8'h60);
		wr(ADR_LFC, 8'h43);
		repeat (2) @(posedge sys_clk_i);
		chk({7'h0, tx_o}, 8'h00);
		wr(ADR_LFC, 8'h03);
		repeat (2) @(posedge sys_clk_i);
		chk({7'h0, tx_o}, 8'h01);
		$display("transmit test done");
		// loopback fill: 64 stored, the 65th is lost
		wr(ADR_MOC, 8'h10);
		for (int k = 0; k < 65; k++) wr(ADR_DATA, 8'(k));
		repeat (10600) @(posedge sys_clk_i);
		rd(ADR_LCF, 8'hFF, 8'h63);
		rd(ADR_LCF, 8'hFF, 8'h61);
		rd(ADR_DATA, 8'hFF, 8'h00);
		$display("overrun test done");
		report_and_stop();
	end
endmodule
bind ulm_top ulm_top_asserts u_chk (.*);
`default_nettype wire
